// ---- dv/instr_cycle_timing_asserts.sv ----
`include "instr_cycle_timing_map.vh"
module instr_cycle_timing_asserts #(parameter NARROW_BUS = 0) (
    input wire logic       mclk,       // Oscillator clock
    input wire logic       reset,      // Synchronous reset
    input wire logic       resin_n,    // External reset input
    input wire logic       start,      // Start pulse
    input wire logic       mem_opnd,   // Memory operand
    input wire logic       cond_taken, // Jump or interrupt taken
    input wire logic       core_rst,   // Core held in reset
    input wire logic       clkout,     // Clock output
    input wire logic       busy,       // Executing
    input wire logic       done,       // Last cycle
    input wire logic [4:0] instr_cls,  // Class code
    input wire logic [6:0] cycles      // Captured latency
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Start that the core accepts
    wire acc = start && !busy && resin_n;
    property p_hold; !resin_n |-> core_rst ##1 !busy; endproperty
    property p_tgl; clkout |=> !clkout; endproperty
    property p_sync_hi; $rose(resin_n) && clkout |=> !clkout [*2] ##1 clkout; endproperty
    property p_sync_lo; $rose(resin_n) && !clkout |=> clkout; endproperty
    property p_acc; acc && instr_cls == `CLS_ADC_ACC |=> done; endproperty
    property p_jmp; acc && instr_cls == `CLS_JMP_DIRECT |=> !done [*2] ##1 done; endproperty
    property p_jcc; acc && instr_cls == `CLS_JCC && cond_taken |=> (busy && !done) [*4] ##1 done; endproperty
    property p_bnd; acc && instr_cls == `CLS_BOUND && cond_taken |=> cycles == (NARROW_BUS ? 7'h40 : 7'h28); endproperty
    property p_and; acc && instr_cls == `CLS_AND_RM_REG
        |=> cycles == ($past(mem_opnd) ? (NARROW_BUS ? 7'h0F : 7'h0C) : 7'h01); endproperty
    a_hold: assert property (p_hold) else $error("core not held");
    a_tgl: assert property (p_tgl) else $error("clock stuck high");
    a_sync_hi: assert property (p_sync_hi) else $error("low stretch wrong");
    a_sync_lo: assert property (p_sync_lo) else $error("phase disturbed");
    a_acc: assert property (p_acc) else $error("acc op latency");
    a_jmp: assert property (p_jmp) else $error("jump latency");
    a_jcc: assert property (p_jcc) else $error("cond jump latency");
    a_bnd: assert property (p_bnd) else $error("bounds latency");
    a_and: assert property (p_and) else $error("operand select");
    c_hi: cover property ($rose(resin_n) && clkout);
    c_lo: cover property ($rose(resin_n) && !clkout);
    c_jcc: cover property (acc && instr_cls == `CLS_JCC);
endmodule // instr_cycle_timing_asserts
bind instr_cycle_timing instr_cycle_timing_asserts #(.NARROW_BUS(NARROW_BUS)) chk_u (.mclk(mclk), .reset(reset),
    .resin_n(resin_n), .start(start), .mem_opnd(mem_opnd), .cond_taken(cond_taken), .core_rst(core_rst),
    .clkout(clkout), .busy(busy), .done(done), .instr_cls(instr_cls), .cycles(cycles));

// ---- dv/instr_cycle_timing_bench.sv ----
`include "instr_cycle_timing_map.vh"
module instr_cycle_timing_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, reset = 1, start = 0, mem_opnd = 0, cond_taken = 0, hold = 1, want_hi = 0;
    logic [4:0] instr_cls = 5'h00;
    logic       core_rst, clkout, busy, done, resin_n;
    logic [6:0] cycles;
    int         fail_count = 0, num_checks = 0, cyc = 0;
    always #5 mclk = ~mclk;
    instr_cycle_timing #(.NARROW_BUS(1)) dut_u (.mclk(mclk), .reset(reset), .resin_n(resin_n), .start(start),
        .instr_cls(instr_cls), .mem_opnd(mem_opnd), .cond_taken(cond_taken), .core_rst(core_rst),
        .clkout(clkout), .busy(busy), .done(done), .cycles(cycles));
    resin_src src_u (.mclk(mclk), .clkout(clkout), .hold(hold), .want_hi(want_hi), .resin_n(resin_n));
    task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Start held two cycles: the second must be refused
    task automatic run(input logic [4:0] c, input logic m, input logic t, input logic [6:0] e);
        logic [6:0] n;
        @(posedge mclk);
        start <= 1;
        instr_cls <= c;
        mem_opnd <= m;
        cond_taken <= t;
        @(posedge mclk);
        n = 1;
        #1;
        while (done !== 1'b1 && n < 7'h50) begin
            @(posedge mclk);
            start <= 0;
            n++;
            #1;
        end
        chk(n, e);
        chk(cycles, e);
        @(posedge mclk);
        start <= 0;
    endtask
    // Reset mid-instruction, then release with clock output high
    task automatic abort_case;
        run(`CLS_BOUND, 0, 1, 7'h40);
        @(posedge mclk);
        start <= 1;
        @(posedge mclk);
        start <= 0;
        hold <= 1;
        repeat (2) @(posedge mclk);
        #1 chk(core_rst, 1);
        @(posedge mclk);
        #1 chk(busy, 0);
        want_hi <= 1;
        hold <= 0;
        @(posedge resin_n);
        repeat (2) begin
            @(posedge mclk);
            #1 chk(clkout, 0);
        end
        @(posedge mclk);
        #1 chk(clkout, 1);
        repeat (6) @(posedge mclk);
        #1 chk(core_rst, 0);
        run(`CLS_JCC, 1, 1, 7'h05);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 0;
        hold <= 0;
        @(posedge resin_n);
        @(posedge mclk);
        #1 chk(clkout, 1);
        @(posedge mclk);
        #1 chk(clkout, 0);
        run(`CLS_ADC_ACC, 1, 0, 7'h01);
        run(`CLS_ADC_IMM_RM, 1, 0, 7'h0D);
        run(`CLS_ADC_RM_REG, 0, 0, 7'h01);
        run(`CLS_ADC_RM_REG, 1, 0, 7'h18);
        run(`CLS_ADD_ACC, 0, 0, 7'h01);
        run(`CLS_ADD_IMM_RM, 1, 0, 7'h20);
        run(`CLS_ADD_RM_REG, 1, 0, 7'h1C);
        run(`CLS_AND_ACC, 0, 0, 7'h01);
        run(`CLS_AND_IMM_RM, 1, 0, 7'h21);
        run(`CLS_AND_RM_REG, 0, 0, 7'h01);
        run(`CLS_AND_RM_REG, 1, 0, 7'h0F);
        run(`CLS_BOUND, 0, 0, 7'h18);
        run(`CLS_JMP_DIRECT, 0, 0, 7'h03);
        run(`CLS_JCC, 0, 0, 7'h03);
        run(`CLS_JCXZ, 0, 1, 7'h04);
        abort_case;
        test_done;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 3000) begin
            fail_count++;
            test_done;
        end
    end
endmodule // instr_cycle_timing_bench

// ---- dv/resin_src.sv ----
module resin_src (
    input  wire logic mclk,    // Oscillator clock
    input  wire logic clkout,  // Observed clock output
    input  wire logic hold,    // Keep reset asserted
    input  wire logic want_hi, // Clock phase wanted at release
    output logic      resin_n  // External reset, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial resin_n = 1'b0;
    // Release only when the clock output will show the wanted phase
    always @(posedge mclk) begin
        if (hold)
            resin_n <= 1'b0;
        else if (clkout != want_hi)
            resin_n <= 1'b1;
    end
endmodule // resin_src

// ---- src/instr_cycle_timing.v ----
// Functional notes
// - Core stays in reset while the active-low reset input is low.
// - Clock output resynchronises on the rising edge of the reset input.
// - Release with clock output high forces it low for two oscillator periods.
// - Release with clock output low leaves its phase unchanged.
// - Cycle counts are identical across all versions of each variant.
// - Immediate-to-accumulator ADC, ADD, AND take one cycle on both variants.
// - ADC immediate to register/memory takes 3 or 13 cycles.
// - ADC register with register/memory: 1 register, 16 or 24 memory.
// - ADD immediate to register/memory: 1 register, 19 or 32 memory.
// - ADD register with register/memory: 1 register, 20 or 28 memory.
// - AND immediate to register/memory: 1 register, 24 or 33 memory.
// - AND register with register/memory: 1 register, 12 or 15 memory.
// - Bounds check 20/40 on wide bus, 24/64 on narrow bus.
// - Direct jump within segment takes three cycles on both variants.
// - Conditional jumps 3/5; count-register-zero jump 3/4.
`include "instr_cycle_timing_map.vh"
module instr_cycle_timing #(
    parameter NARROW_BUS = 0 // 0: 16-bit bus variant, 1: 8-bit bus variant
) (
    input  wire       mclk,       // Oscillator clock
    input  wire       reset,      // Synchronous reset, active high
    input  wire       resin_n,    // External reset input, active low
    input  wire       start,      // Start an instruction, one-cycle pulse
    input  wire [4:0] instr_cls,  // Instruction class code
    input  wire       mem_opnd,   // Operand is memory, else register
    input  wire       cond_taken, // Jump taken or bounds interrupt taken
    output wire       core_rst,   // Core held in reset
    output wire       clkout,     // System clock output
    output wire       busy,       // Instruction executing
    output wire       done,       // Last cycle of instruction, pulse
    output wire [6:0] cycles      // Cycle count of the last started instruction
);

    // Execution state codes
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    // Previous sample of the reset input
    reg       rst_in_ff;
    // Clock output divider and low-stretch counter
    reg       clk_ff;
    reg [1:0] hold_ff;
    // Execution state and remaining-cycle counter
    reg       state_ff;
    reg [6:0] cnt_ff;
    // Latency of the last accepted instruction
    reg [6:0] cyc_ff;
    // Next-state values
    reg       nxt_clk;
    reg [1:0] nxt_hold;
    reg [6:0] nxt_cnt;
    reg       nxt_state;
    // Latency of the class now on the inputs
    reg [6:0] lat;
    // Release edge and start qualifier
    wire      rel_edge;
    wire      accept;

    // Pick wide or narrow figure
    function [6:0] pick;
        input       nb;
        input [6:0] w;
        input [6:0] n;
        begin
            pick = nb ? n : w;
        end
    endfunction

    // Register or memory figure
    function [6:0] rm;
        input       m;
        input [6:0] r;
        input [6:0] mv;
        begin
            rm = m ? mv : r;
        end
    endfunction

    // Latency lookup; same figures for every version of a variant
    always @* begin
        lat = `CYC_ONE;
        case (instr_cls)
            // Immediate to accumulator: single cycle everywhere
            `CLS_ADC_ACC, `CLS_ADD_ACC, `CLS_AND_ACC: begin
                lat = `CYC_ONE;
            end
            // Carry-add immediate: one figure whatever the operand kind
            `CLS_ADC_IMM_RM: begin
                lat = pick(NARROW_BUS, `CYC_ADC_IMM_W, `CYC_ADC_IMM_N);
            end
            // Carry-add between register and register/memory
            `CLS_ADC_RM_REG: begin
                lat = rm(mem_opnd, `CYC_ONE, pick(NARROW_BUS, `CYC_ADC_RM_W, `CYC_ADC_RM_N));
            end
            // Add immediate to register/memory
            `CLS_ADD_IMM_RM: begin
                lat = rm(mem_opnd, `CYC_ONE, pick(NARROW_BUS, `CYC_ADD_IMM_W, `CYC_ADD_IMM_N));
            end
            // Add between register and register/memory
            `CLS_ADD_RM_REG: begin
                lat = rm(mem_opnd, `CYC_ONE, pick(NARROW_BUS, `CYC_ADD_RM_W, `CYC_ADD_RM_N));
            end
            // Logical AND immediate to register/memory
            `CLS_AND_IMM_RM: begin
                lat = rm(mem_opnd, `CYC_ONE, pick(NARROW_BUS, `CYC_AND_IMM_W, `CYC_AND_IMM_N));
            end
            // Logical AND between register and register/memory
            `CLS_AND_RM_REG: begin
                lat = rm(mem_opnd, `CYC_ONE, pick(NARROW_BUS, `CYC_AND_RM_W, `CYC_AND_RM_N));
            end
            // Bounds check: the interrupt path is the long one
            `CLS_BOUND: begin
                if (cond_taken) begin
                    lat = pick(NARROW_BUS, `CYC_BOUND_INT_W, `CYC_BOUND_INT_N);
                end else begin
                    lat = pick(NARROW_BUS, `CYC_BOUND_OK_W, `CYC_BOUND_OK_N);
                end
            end
            // Direct jump within the segment
            `CLS_JMP_DIRECT: begin
                lat = `CYC_JMP;
            end
            // Conditional jump: taken costs two more cycles
            `CLS_JCC: begin
                if (cond_taken) begin
                    lat = `CYC_JCC_TAKEN;
                end else begin
                    lat = `CYC_JMP;
                end
            end
            // Count-register-zero jump: taken costs one more cycle
            `CLS_JCXZ: begin
                if (cond_taken) begin
                    lat = `CYC_JCXZ_TAKEN;
                end else begin
                    lat = `CYC_JMP;
                end
            end
            // Unused class codes finish in one cycle
            default: begin
                lat = `CYC_ONE;
            end
        endcase
    end

    // Rising edge of the reset input against the previous sample
    assign rel_edge = resin_n && !rst_in_ff;

    // Clock output next state: a release seen while high stretches the low phase
    always @* begin
        nxt_clk  = ~clk_ff;
        nxt_hold = hold_ff;
        if (rel_edge && clk_ff) begin
            nxt_clk  = 1'b0;
            nxt_hold = `CLKOUT_HOLD_PER - 2'h1;
        end else if (hold_ff != 2'h0) begin
            nxt_clk  = 1'b0;
            nxt_hold = hold_ff - 2'h1;
        end else begin
            nxt_clk  = ~clk_ff;
            nxt_hold = 2'h0;
        end
    end

    // Previous reset-input sample; runs through reset as well, so the first
    // edge after reset compares against a real sample and sees no false release
    always @(posedge mclk) begin
        rst_in_ff <= resin_n;
    end

    // Clock output divider
    always @(posedge mclk) begin
        if (reset) begin
            clk_ff  <= 1'b0;
            hold_ff <= 2'h0;
        end else begin
            clk_ff  <= nxt_clk;
            hold_ff <= nxt_hold;
        end
    end

    // Start is taken only while idle and out of reset
    assign accept = start && (state_ff == ST_IDLE) && resin_n;

    // Execution counter next state
    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state = ST_EXEC;
                    nxt_cnt   = lat;
                end
            end
            ST_EXEC: begin
                nxt_cnt = cnt_ff - 7'h01;
                if (cnt_ff == 7'h01) begin
                    nxt_state = ST_IDLE;
                    nxt_cnt   = 7'h00;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cnt   = 7'h00;
            end
        endcase
    end

    // Execution state; a low reset input aborts and holds the core idle
    always @(posedge mclk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 7'h00;
        end else if (!resin_n) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 7'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Latency capture for the cycles output
    always @(posedge mclk) begin
        if (reset) begin
            cyc_ff <= 7'h00;
        end else if (accept) begin
            cyc_ff <= lat;
        end
    end

    assign core_rst = ~resin_n | reset;
    assign clkout   = clk_ff;
    assign busy     = (state_ff == ST_EXEC);
    assign done     = (state_ff == ST_EXEC) && (cnt_ff == 7'h01);
    assign cycles   = cyc_ff;

endmodule // instr_cycle_timing

// ---- src/instr_cycle_timing_map.vh ----
`ifndef INSTR_CYCLE_TIMING_MAP_VH
`define INSTR_CYCLE_TIMING_MAP_VH
// Instruction class codes
`define CLS_ADC_ACC      5'h00
`define CLS_ADC_IMM_RM   5'h01
`define CLS_ADC_RM_REG   5'h02
`define CLS_ADD_ACC      5'h03
`define CLS_ADD_IMM_RM   5'h04
`define CLS_ADD_RM_REG   5'h05
`define CLS_AND_ACC      5'h06
`define CLS_AND_IMM_RM   5'h07
`define CLS_AND_RM_REG   5'h08
`define CLS_BOUND        5'h09
`define CLS_JMP_DIRECT   5'h0A
`define CLS_JCC          5'h0B
`define CLS_JCXZ         5'h0C
// Cycle counts, wide bus / narrow bus
`define CYC_ONE          7'h01
`define CYC_ADC_IMM_W    7'h03
`define CYC_ADC_IMM_N    7'h0D
`define CYC_ADC_RM_W     7'h10
`define CYC_ADC_RM_N     7'h18
`define CYC_ADD_IMM_W    7'h13
`define CYC_ADD_IMM_N    7'h20
`define CYC_ADD_RM_W     7'h14
`define CYC_ADD_RM_N     7'h1C
`define CYC_AND_IMM_W    7'h18
`define CYC_AND_IMM_N    7'h21
`define CYC_AND_RM_W     7'h0C
`define CYC_AND_RM_N     7'h0F
`define CYC_BOUND_OK_W   7'h14
`define CYC_BOUND_INT_W  7'h28
`define CYC_BOUND_OK_N   7'h18
`define CYC_BOUND_INT_N  7'h40
`define CYC_JMP          7'h03
`define CYC_JCC_TAKEN    7'h05
`define CYC_JCXZ_TAKEN   7'h04
// Clock output low hold after reset release, in oscillator periods
`define CLKOUT_HOLD_PER  2'h2
`endif
